/* hdl/branch_jump_execute.sv */
// Executor for branch, jump, long call, long jump and byte-move instructions of an 8-bit core.
`timescale 1ns/1ps
module branch_jump_execute
	import branch_jump_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] code_data,
	output logic [15:0] code_addr,
	input wire logic [7:0] accumulator,
	input wire logic [15:0] data_pointer,
	input wire logic carry,
	input wire logic [7:0] bit_latch,
	input wire logic [7:0] ram_rdata,
	output logic [7:0] ram_raddr,
	output ram_write_s ram_wr,
	output bit_access_s bit_clear,
	output logic [15:0] pc,
	output logic [7:0] stack_pointer,
	output logic illegal_op
);
	typedef enum {FETCH, OPER1, OPER2, PUSH_LOW, PUSH_HIGH, MOVE_WRITE} state_e;

	state_e state_reg, state_next;
	logic [15:0] pc_reg, pc_next;
	logic [7:0] sp_reg, sp_next;
	logic [7:0] op_reg, op_next;
	logic [7:0] b1_reg, b1_next;
	logic [15:0] fetch_reg, fetch_next;
	ram_write_s wr_reg, wr_next;
	bit_access_s clr_reg, clr_next;
	logic ill_reg, ill_next;
	logic [7:0] bit_sel;
	logic bit_val;
	logic [15:0] rel_target;

	////////////////////////////////////////////////////////////////////////////
	// Bit selection reads the output latch, so a port bit never reflects the pin level.
	assign bit_sel = b1_reg;
	assign bit_val = bit_latch[bit_sel[2:0]];
	assign ram_raddr = b1_reg;
	// The offset byte sits at fetch_reg, so the next instruction starts one further on.
	// The sign-extended offset is added there, past the whole instruction.
	assign rel_target = fetch_reg + LEN_ONE + {{8{code_data[7]}}, code_data};

	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		sp_next = sp_reg;
		op_next = op_reg;
		b1_next = b1_reg;
		fetch_next = fetch_reg;
		wr_next = '0;
		clr_next = '0;
		ill_next = 1'b0;
		case (state_reg)
			FETCH: begin
				op_next = code_data;
				fetch_next = fetch_reg + LEN_ONE;
				state_next = OPER1;
				if (code_data == OP_INDIRECT_JUMP) begin
					// Operands are only read, so accumulator, pointer and flags stay intact.
					pc_next = {8'h00, accumulator} + data_pointer;
					fetch_next = {8'h00, accumulator} + data_pointer;
					state_next = FETCH;
				end else if (!(code_data inside {OP_JUMP_IF_BIT_SET, OP_JUMP_BIT_SET_AND_CLEAR,
						OP_JUMP_IF_BIT_CLEAR, OP_JUMP_IF_CARRY, OP_JUMP_IF_NO_CARRY, OP_JUMP_IF_ACC_ZERO,
						OP_JUMP_IF_ACC_NONZERO, OP_LONG_CALL, OP_LONG_JUMP, OP_MOVE_DIR_DIR})) begin
					ill_next = 1'b1;
					pc_next = fetch_reg + LEN_ONE;
					state_next = FETCH;
				end
			end
			OPER1: begin
				b1_next = code_data;
				fetch_next = fetch_reg + LEN_ONE;
				state_next = OPER2;
				case (op_reg)
					OP_JUMP_IF_CARRY: begin
						pc_next = carry ? rel_target : fetch_reg + LEN_ONE;
						fetch_next = pc_next;
						state_next = FETCH;
					end
					OP_JUMP_IF_NO_CARRY: begin
						// Carry is an input only; this block has no path to modify it.
						pc_next = !carry ? rel_target : fetch_reg + LEN_ONE;
						fetch_next = pc_next;
						state_next = FETCH;
					end
					OP_JUMP_IF_ACC_ZERO: begin
						pc_next = (accumulator == BYTE_ZERO) ? rel_target : fetch_reg + LEN_ONE;
						fetch_next = pc_next;
						state_next = FETCH;
					end
					OP_JUMP_IF_ACC_NONZERO: begin
						pc_next = (|accumulator) ? rel_target : fetch_reg + LEN_ONE;
						fetch_next = pc_next;
						state_next = FETCH;
					end
					default: begin
					end
				endcase
			end
			OPER2: begin
				fetch_next = fetch_reg + LEN_ONE;
				pc_next = fetch_reg + LEN_ONE;
				state_next = FETCH;
				case (op_reg)
					OP_JUMP_IF_BIT_SET: begin
						if (bit_val) begin
							pc_next = rel_target;
						end
					end
					OP_JUMP_IF_BIT_CLEAR: begin
						if (!bit_val) begin
							pc_next = rel_target;
						end
					end
					OP_JUMP_BIT_SET_AND_CLEAR: begin
						if (bit_val) begin
							pc_next = rel_target;
						end
						clr_next.en = 1'b1;
						clr_next.addr = b1_reg;
					end
					OP_LONG_JUMP: begin
						pc_next = {b1_reg, code_data};
					end
					OP_LONG_CALL: begin
						// Target waits in b1_reg and op_reg until both return bytes are pushed.
						pc_next = fetch_reg + LEN_ONE;
						op_next = code_data;
						state_next = PUSH_LOW;
					end
					OP_MOVE_DIR_DIR: begin
						op_next = code_data;
						state_next = MOVE_WRITE;
					end
					default: begin
					end
				endcase
				if (op_reg != OP_LONG_CALL && op_reg != OP_MOVE_DIR_DIR) begin
					fetch_next = pc_next;
				end else begin
					fetch_next = fetch_reg + LEN_ONE;
				end
			end
			PUSH_LOW: begin
				sp_next = sp_reg + 8'h01;
				wr_next.en = 1'b1;
				wr_next.addr = sp_reg + 8'h01;
				wr_next.data = pc_reg[7:0];
				state_next = PUSH_HIGH;
			end
			PUSH_HIGH: begin
				sp_next = sp_reg + 8'h01;
				wr_next.en = 1'b1;
				wr_next.addr = sp_reg + 8'h01;
				wr_next.data = pc_reg[15:8];
				pc_next = {b1_reg, op_reg};
				fetch_next = {b1_reg, op_reg};
				state_next = FETCH;
			end
			MOVE_WRITE: begin
				// Source is only read; the copy goes to the destination held in op_reg.
				wr_next.en = 1'b1;
				wr_next.addr = op_reg;
				wr_next.data = ram_rdata;
				pc_next = fetch_reg;
				state_next = FETCH;
			end
			default: begin
				state_next = FETCH;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= FETCH;
			pc_reg <= PC_RESET;
			sp_reg <= SP_RESET;
			op_reg <= BYTE_ZERO;
			b1_reg <= BYTE_ZERO;
			fetch_reg <= PC_RESET;
			wr_reg <= '0;
			clr_reg <= '0;
			ill_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			sp_reg <= sp_next;
			op_reg <= op_next;
			b1_reg <= b1_next;
			fetch_reg <= fetch_next;
			wr_reg <= wr_next;
			clr_reg <= clr_next;
			ill_reg <= ill_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign code_addr = fetch_reg;
	assign pc = pc_reg;
	assign stack_pointer = sp_reg;
	assign ram_wr = wr_reg;
	assign bit_clear = clr_reg;
	assign illegal_op = ill_reg;
endmodule : branch_jump_execute

/* hdl/branch_jump_pkg.sv */
// Package with opcodes, byte lengths, reset values and bus structs for the control-transfer executor.
package branch_jump_pkg;
	localparam logic [7:0] OP_JUMP_IF_BIT_SET = 8'h20;
	localparam logic [7:0] OP_JUMP_BIT_SET_AND_CLEAR = 8'h10;
	localparam logic [7:0] OP_JUMP_IF_BIT_CLEAR = 8'h30;
	localparam logic [7:0] OP_JUMP_IF_CARRY = 8'h40;
	localparam logic [7:0] OP_JUMP_IF_NO_CARRY = 8'h50;
	localparam logic [7:0] OP_JUMP_IF_ACC_ZERO = 8'h60;
	localparam logic [7:0] OP_JUMP_IF_ACC_NONZERO = 8'h70;
	localparam logic [7:0] OP_INDIRECT_JUMP = 8'h73;
	localparam logic [7:0] OP_LONG_CALL = 8'h12;
	localparam logic [7:0] OP_LONG_JUMP = 8'h02;
	localparam logic [7:0] OP_MOVE_DIR_DIR = 8'h85;
	localparam logic [15:0] LEN_ONE = 16'h0001;
	localparam logic [15:0] LEN_TWO = 16'h0002;
	localparam logic [15:0] LEN_THREE = 16'h0003;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} ram_write_s;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
	} bit_access_s;
endpackage : branch_jump_pkg

/* dv/branch_jump_props.sv */
// Port checker for the control-transfer executor.
`timescale 1ns/1ps
module branch_jump_props
	import branch_jump_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] code_data,
	input wire logic [15:0] code_addr,
	input wire logic [7:0] accumulator,
	input wire logic [15:0] data_pointer,
	input wire logic [7:0] ram_raddr,
	input wire ram_write_s ram_wr,
	input wire bit_access_s bit_clear,
	input wire logic [15:0] pc,
	input wire logic [7:0] stack_pointer
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	reset_state_a: assert property ($past(srst) |-> pc == PC_RESET && stack_pointer == SP_RESET)
		else $error("bad reset state");
	clear_pulse_a: assert property (bit_clear.en |=> !bit_clear.en)
		else $error("clear too long");
	clear_addr_a: assert property (bit_clear.en |-> bit_clear.addr == ram_raddr)
		else $error("clear address");
	push_pair_a: assert property (ram_wr.en && $past(ram_wr.en) |-> ram_wr.addr == stack_pointer
		&& stack_pointer == $past(stack_pointer) + 8'h01) else $error("second push");
	sp_step_a: assert property ($changed(stack_pointer) |-> ram_wr.en
		&& stack_pointer == $past(stack_pointer) + 8'h01) else $error("stack step");
	push_max_a: assert property (ram_wr.en [*2] |=> !ram_wr.en)
		else $error("too many pushes");
	// Push and move-write cycles also show code_addr equal to pc; a write in the next cycle marks them.
	indirect_target_a: assert property (code_addr == pc && code_data == OP_INDIRECT_JUMP ##1 !ram_wr.en |->
		pc == $past(data_pointer) + {8'h00, $past(accumulator)}) else $error("indirect target");
	// Only a real opcode fetch is followed by the fetch address running one ahead of pc.
	jump_quiet_a: assert property (code_addr == pc && code_data == OP_LONG_JUMP ##1 code_addr == pc + 16'h0001 |->
		(!ram_wr.en && $stable(stack_pointer)) [*4]) else $error("jump touched stack");
	cover property (bit_clear.en);
	cover property (ram_wr.en [*2]);
	cover property (!ram_wr.en ##1 ram_wr.en ##1 !ram_wr.en);
endmodule : branch_jump_props
bind branch_jump_execute branch_jump_props u_props (.sys_clk, .srst, .code_data, .code_addr, .accumulator,
	.data_pointer, .ram_raddr, .ram_wr, .bit_clear, .pc, .stack_pointer);

/* dv/code_ram_model.sv */
// Program memory and internal data memory facing the executor.
`timescale 1ns/1ps
module code_ram_model
	import branch_jump_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [15:0] code_addr,
	output logic [7:0] code_data,
	input wire logic [7:0] ram_raddr,
	output logic [7:0] ram_rdata,
	input wire ram_write_s ram_wr
);
	logic [7:0] rom [0:65535];
	logic [7:0] ram [0:255];
	// Free code space holds an unhandled opcode, so a stray fetch cannot pass for a branch.
	initial begin
		for (int i = 0; i < 65536; i++) rom[i] = 8'ha5;
	end
	assign code_data = rom[code_addr];
	assign ram_rdata = ram[ram_raddr];
	always @(posedge sys_clk) begin
		if (ram_wr.en) ram[ram_wr.addr] <= ram_wr.data;
	end
endmodule : code_ram_model

/* dv/branch_jump_execute_bench.sv */
// Self-checking bench for the control-transfer executor.
`timescale 1ns/1ps
module branch_jump_execute_bench
	import branch_jump_pkg::*;
;
	logic sys_clk = 0, srst = 1, carry = 0;
	logic [7:0] accumulator = 0, bit_latch = 0, code_data, ram_rdata, ram_raddr, stack_pointer;
	logic [15:0] data_pointer = 0, code_addr, pc;
	ram_write_s ram_wr;
	bit_access_s bit_clear;
	logic illegal_op;
	int fail_count = 0, checked = 0, clears = 0;
	initial forever #25 sys_clk = ~sys_clk;
	branch_jump_execute i_dut (.sys_clk, .srst, .code_data, .code_addr, .accumulator, .data_pointer, .carry,
		.bit_latch, .ram_rdata, .ram_raddr, .ram_wr, .bit_clear, .pc, .stack_pointer, .illegal_op);
	code_ram_model m (.sys_clk, .code_addr, .code_data, .ram_raddr, .ram_rdata, .ram_wr);
	always @(posedge bit_clear.en) clears++;
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : step
	task boot(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		@(negedge sys_clk);
		srst = 1;
		m.rom[0] = b0;
		m.rom[1] = b1;
		m.rom[2] = b2;
		clears = 0;
		step(4);
		srst = 0;
	endtask : boot
	task t_bit;
		logic [7:0] ops [3] = '{OP_JUMP_IF_BIT_SET, OP_JUMP_BIT_SET_AND_CLEAR, OP_JUMP_IF_BIT_CLEAR};
		for (int i = 0; i < 6; i++) begin
			// Other latch bits are inverted so a wrong bit index flips the outcome.
			bit_latch = i[0] ? 8'h08 : 8'hf7;
			boot(ops[i / 2], 8'h23, 8'h10);
			step(3);
			check("bit pc", pc, ((i / 2 == 2) ^ i[0]) ? 16'h0013 : 16'h0003);
			check("clears", 16'(clears), 16'(i / 2 == 1));
		end
		$display("t_bit done");
	endtask : t_bit
	task t_flag;
		logic [7:0] ops [4] = '{OP_JUMP_IF_CARRY, OP_JUMP_IF_NO_CARRY, OP_JUMP_IF_ACC_ZERO, OP_JUMP_IF_ACC_NONZERO};
		for (int i = 0; i < 8; i++) begin
			carry = i[0];
			accumulator = i[0] ? 8'h80 : 8'h00;
			boot(ops[i / 2], 8'hf0, 8'h00);
			step(2);
			check("flag pc", pc, ((i / 2 == 1 || i / 2 == 2) ^ i[0]) ? 16'hfff2 : 16'h0002);
		end
		$display("t_flag done");
	endtask : t_flag
	task t_ind;
		accumulator = 8'hff;
		data_pointer = 16'h12ff;
		boot(OP_INDIRECT_JUMP, 8'h00, 8'h00);
		step(1);
		check("indirect pc", pc, 16'h13fe);
		check("indirect fetch", code_addr, 16'h13fe);
		$display("t_ind done");
	endtask : t_ind
	task t_long;
		boot(OP_LONG_CALL, 8'h12, 8'h34);
		step(5);
		check("call pc", pc, 16'h1234);
		check("call sp", {8'h00, stack_pointer}, 16'h0009);
		step(1);
		check("push low", {8'h00, m.ram[8]}, 16'h0003);
		check("push high", {8'h00, m.ram[9]}, 16'h0000);
		boot(OP_LONG_JUMP, 8'hab, 8'hcd);
		step(3);
		check("jump pc", pc, 16'habcd);
		check("jump sp", {8'h00, stack_pointer}, 16'h0007);
		$display("t_long done");
	endtask : t_long
	task t_move;
		m.ram[8'h30] = 8'h5a;
		boot(OP_MOVE_DIR_DIR, 8'h30, 8'h40);
		step(4);
		check("move pc", pc, 16'h0003);
		step(1);
		check("move dest", {8'h00, m.ram[8'h40]}, 16'h005a);
		check("move src", {8'h00, m.ram[8'h30]}, 16'h005a);
		$display("t_move done");
	endtask : t_move
	task t_illegal;
		// A move form other than direct to direct is left to the core, so it must be flagged and skipped.
		boot(8'he5, OP_JUMP_IF_CARRY, 8'h00);
		step(1);
		check("illegal flag", 16'(illegal_op), 16'h0001);
		check("illegal pc", pc, 16'h0001);
		step(1);
		check("illegal pulse", 16'(illegal_op), 16'h0000);
		$display("t_illegal done");
	endtask : t_illegal
	task close_out;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	initial begin
		t_bit();
		t_flag();
		t_ind();
		t_long();
		t_move();
		t_illegal();
		close_out();
	end
endmodule : branch_jump_execute_bench
